// ---- core/pad_pkg.sv ----
package pad_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFF      = 8'h00;
    localparam logic [7:0] PE_SEL_OFF    = 8'h04;
    localparam logic [7:0] PE_DDR_OFF    = 8'h08;
    localparam logic [7:0] PE_DOUT_OFF   = 8'h0c;
    localparam logic [7:0] PE_DIN_OFF    = 8'h10;
    localparam logic [7:0] PE_PUR_OFF    = 8'h14;
    localparam logic [7:0] SYS_PUDR_OFF  = 8'h18;
    localparam logic [7:0] IRQ_CFG_OFF   = 8'h1c;
    localparam logic [7:0] IRQ_STAT_OFF  = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFF  = 8'h24;
    localparam logic [7:0] CAN_GPIO_PULLUP_ENABLE_BITS_OFF = 8'h28;
    // Field positions
    localparam int CTRL_CAN_PP     = 0;
    localparam int CTRL_LOWPOWER   = 1;
    localparam int PUDR_IRQ        = 0;
    localparam int CFG_EDGE_A      = 0;
    localparam int CFG_EDGE_B      = 1;
    localparam int STAT_REQ_A      = 0;
    localparam int STAT_REQ_B      = 1;
    // Widths and reset values
    localparam int NUM_SHARED      = 6;
    localparam logic [5:0] SEL_RST  = 6'h00;
    localparam logic [5:0] PUR_RST  = 6'h3f;
    localparam logic [1:0] CTRL_RST = 2'h0;
endpackage : pad_pkg

// ---- core/req_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser with an asynchronous path selected in low power
module req_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic req_n,
    input  wire logic async_mode,
    output logic      req_level_n
);
    logic meta_r;
    logic sync_r;

    // First stage only feeds the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= req_n;
            sync_r <= meta_r;
        end
    end

    // Clockless path while stopped or waiting
    assign req_level_n = async_mode ? req_n : sync_r; // RL10 RL11
endmodule : req_sync

// ---- core/shared_pin.sv ----
`timescale 1ns/1ps
// One timer/port E shared pad slice
module shared_pin (
    input  wire logic sel_gpio,
    input  wire logic gpio_dir,
    input  wire logic gpio_dout,
    input  wire logic gpio_pur,
    input  wire logic tmr_out,
    input  wire logic tmr_oe,
    output logic      pad_out,
    output logic      pad_oe,
    output logic      pad_pu
);
    // Mux between timer and general-purpose I/O
    assign pad_out = sel_gpio ? gpio_dout : tmr_out; // RL14
    assign pad_oe  = sel_gpio ? gpio_dir  : tmr_oe;  // RL8
    // Pull-up only while the pad is not driven
    assign pad_pu  = gpio_pur & ~pad_oe; // RL9
endmodule : shared_pin

// ---- core/pad_pins.sv ----
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
// What this block does
// RL1 - CAN transmit pin resets as open drain with pull-up enabled.
// RL2 - Open-drain pin driving low has its pull-up switched off.
// RL3 - Open-drain pin driving high keeps pull-up unless its enable is cleared.
// RL4 - Push-pull pin never has its pull-up enabled.
// RL5 - Two pins shared between timer C channels 0, 1 and port E.
// RL6 - Four pins shared between timer D channels 0 to 3 and port E.
// RL7 - Shared pins come out of reset in timer function.
// RL8 - In GPIO use each port E pin is input or output separately.
// RL9 - Clearing a port E pull-up enable bit turns that pull-up off.
// RL10 - In stop and wait the request inputs act without the clock; the request outputs and irq here still register on pclk.
// RL11 - Otherwise request inputs are synchronised before use.
// RL12 - Each request input is level or falling-edge sensitive.
// RL13 - Setting the system pull-up disable bit removes request pull-ups.
// RL14 - Per-pin select routes each shared pin to timer or GPIO.
module pad_pins #(
    parameter int N = pad_pkg::NUM_SHARED
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         can_tx_data,
    output logic              can_tx_out,
    output logic              can_tx_oe,
    output logic              can_tx_pu,
    input  wire logic [1:0]   timer_c_out,
    input  wire logic [1:0]   timer_c_oe,
    input  wire logic [3:0]   timer_d_out,
    input  wire logic [3:0]   timer_d_oe,
    output logic      [1:0]   timer_c_in,
    output logic      [3:0]   timer_d_in,
    input  wire logic [N-1:0] shared_in,
    output logic      [N-1:0] shared_out,
    output logic      [N-1:0] shared_oe,
    output logic      [N-1:0] shared_pu,
    input  wire logic         ext_request_a_pin_n,
    input  wire logic         ext_request_b_pin_n,
    output logic              ext_request_pu,
    output logic              ext_req_a_n,
    output logic              ext_req_b_n,
    output logic              irq
);
    logic [1:0]   ctrl_r;
    logic [N-1:0] sel_r;
    logic [N-1:0] ddr_r;
    logic [N-1:0] dout_r;
    logic [N-1:0] pur_r;
    logic [N-1:0] din_r;
    logic         pudr_irq_r;
    logic [1:0]   cfg_r;
    logic [1:0]   stat_r;
    logic [1:0]   mask_r;
    logic         can_gpio_pullup_enable_bits_r;
    logic [1:0]   prev_n_r;
    logic         req_a_n;
    logic         req_b_n;
    logic [N-1:0] mux_out;
    logic [N-1:0] mux_oe;
    logic [N-1:0] mux_pu;
    logic [N-1:0] tmr_out;
    logic [N-1:0] tmr_oe;
    logic [1:0]   req_n;
    logic [1:0]   event_set;
    logic         wr;
    logic         rd;
    logic         low_power;
    logic [31:0]  rdata_nxt;
    logic         mapped;

    assign wr        = psel & penable & pwrite;
    assign rd        = psel & ~penable & ~pwrite;
    assign low_power = ctrl_r[pad_pkg::CTRL_LOWPOWER];
    assign tmr_out   = N'({timer_d_out, timer_c_out}); // RL5 RL6
    assign tmr_oe    = N'({timer_d_oe, timer_c_oe});

    // Control and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r      <= pad_pkg::CTRL_RST; // RL1
            sel_r       <= N'(pad_pkg::SEL_RST); // RL7
            ddr_r       <= '0;
            dout_r      <= '0;
            pur_r       <= N'(pad_pkg::PUR_RST);
            pudr_irq_r  <= 1'b0;
            cfg_r       <= 2'h0;
            mask_r      <= 2'h0;
            can_gpio_pullup_enable_bits_r <= 1'b1; // RL1
        end else if (wr) begin
            unique case (paddr)
                pad_pkg::CTRL_OFF:      ctrl_r <= pwdata[1:0];
                pad_pkg::PE_SEL_OFF:    sel_r  <= pwdata[N-1:0]; // RL14
                pad_pkg::PE_DDR_OFF:    ddr_r  <= pwdata[N-1:0]; // RL8
                pad_pkg::PE_DOUT_OFF:   dout_r <= pwdata[N-1:0];
                pad_pkg::PE_PUR_OFF:    pur_r  <= pwdata[N-1:0]; // RL9
                pad_pkg::SYS_PUDR_OFF:
                    pudr_irq_r <= pwdata[pad_pkg::PUDR_IRQ]; // RL13
                pad_pkg::IRQ_CFG_OFF:   cfg_r  <= pwdata[1:0]; // RL12
                pad_pkg::IRQ_MASK_OFF:  mask_r <= pwdata[1:0];
                pad_pkg::CAN_GPIO_PULLUP_ENABLE_BITS_OFF: can_gpio_pullup_enable_bits_r <= pwdata[0];
                default: ;
            endcase
        end
    end

    // Shared pad slices, one per timer channel
    for (genvar i = 0; i < N; i++) begin : g_pin
        shared_pin u_pin (
            .sel_gpio  (sel_r[i]),
            .gpio_dir  (ddr_r[i]),
            .gpio_dout (dout_r[i]),
            .gpio_pur  (pur_r[i]),
            .tmr_out   (tmr_out[i]),
            .tmr_oe    (tmr_oe[i]),
            .pad_out   (mux_out[i]),
            .pad_oe    (mux_oe[i]),
            .pad_pu    (mux_pu[i])
        );
    end

    // Registered pad drive and input capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_out <= '0;
            shared_oe  <= '0;
            shared_pu  <= N'(pad_pkg::PUR_RST);
            din_r      <= '0;
            timer_c_in <= 2'h0;
            timer_d_in <= 4'h0;
        end else begin
            shared_out <= mux_out;
            shared_oe  <= mux_oe;
            shared_pu  <= mux_pu; // RL9
            din_r      <= shared_in;
            // Timer sees its pin only while its select bit is clear
            timer_c_in <= shared_in[1:0] & ~sel_r[1:0]; // RL5
            timer_d_in <= shared_in[5:2] & ~sel_r[5:2]; // RL6
        end
    end

    // CAN transmit pad; open drain never drives high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            can_tx_out <= 1'b0;
            can_tx_oe  <= 1'b0;
            can_tx_pu  <= 1'b1; // RL1
        end else if (ctrl_r[pad_pkg::CTRL_CAN_PP]) begin
            can_tx_out <= can_tx_data;
            can_tx_oe  <= 1'b1;
            can_tx_pu  <= 1'b0; // RL4
        end else begin
            can_tx_out <= 1'b0;
            can_tx_oe  <= ~can_tx_data;
            // Low drive drops pull-up to save current
            can_tx_pu  <= can_tx_data & can_gpio_pullup_enable_bits_r; // RL2 RL3
        end
    end

    // Request input conditioning
    req_sync u_sync_a (
        .pclk        (pclk),
        .presetn     (presetn),
        .req_n       (ext_request_a_pin_n),
        .async_mode  (low_power),
        .req_level_n (req_a_n)
    );
    req_sync u_sync_b (
        .pclk        (pclk),
        .presetn     (presetn),
        .req_n       (ext_request_b_pin_n),
        .async_mode  (low_power),
        .req_level_n (req_b_n)
    );
    assign req_n = {req_b_n, req_a_n};

    // Falling edge or low level per input
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            event_set[k] = cfg_r[k] ? (prev_n_r[k] & ~req_n[k])
                                    : ~req_n[k]; // RL12
        end
    end

    // Sticky status, write one to clear; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r   <= 2'h0;
            prev_n_r <= 2'h3;
        end else begin
            prev_n_r <= req_n;
            if (wr && paddr == pad_pkg::IRQ_STAT_OFF) begin
                stat_r <= (stat_r & ~pwdata[1:0]) | event_set;
            end else begin
                stat_r <= stat_r | event_set;
            end
        end
    end

    // Outputs to the interrupt controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq            <= 1'b0;
            ext_req_a_n    <= 1'b1;
            ext_req_b_n    <= 1'b1;
            ext_request_pu <= 1'b1;
        end else begin
            irq            <= |(stat_r & mask_r);
            ext_req_a_n    <= req_a_n;
            ext_req_b_n    <= req_b_n;
            ext_request_pu <= ~pudr_irq_r; // RL13
        end
    end

    // Read mux
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        mapped    = 1'b1;
        unique case (paddr)
            pad_pkg::CTRL_OFF:      rdata_nxt[1:0]   = ctrl_r;
            pad_pkg::PE_SEL_OFF:    rdata_nxt[N-1:0] = sel_r;
            pad_pkg::PE_DDR_OFF:    rdata_nxt[N-1:0] = ddr_r;
            pad_pkg::PE_DOUT_OFF:   rdata_nxt[N-1:0] = dout_r;
            pad_pkg::PE_DIN_OFF:    rdata_nxt[N-1:0] = din_r;
            pad_pkg::PE_PUR_OFF:    rdata_nxt[N-1:0] = pur_r;
            pad_pkg::SYS_PUDR_OFF:  rdata_nxt[0]     = pudr_irq_r;
            pad_pkg::IRQ_CFG_OFF:   rdata_nxt[1:0]   = cfg_r;
            pad_pkg::IRQ_STAT_OFF:  rdata_nxt[1:0]   = stat_r;
            pad_pkg::IRQ_MASK_OFF:  rdata_nxt[1:0]   = mask_r;
            pad_pkg::CAN_GPIO_PULLUP_ENABLE_BITS_OFF: rdata_nxt[0]     = can_gpio_pullup_enable_bits_r;
            default:                mapped           = 1'b0;
        endcase
    end

    // Zero-wait APB answer, data latched in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (rd) begin
                prdata <= rdata_nxt;
            end
        end
    end

    // Assertions
    property p_od_low;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl_r[0] && !can_tx_data) |=> !can_tx_pu;
    endproperty
    a_od_low: assert property (p_od_low) else $error("od low pullup on"); // RL2

    property p_od_high;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl_r[0] && can_tx_data) |=> can_tx_pu == $past(can_gpio_pullup_enable_bits_r);
    endproperty
    a_od_high: assert property (p_od_high) else $error("od high pullup"); // RL3

    property p_pp;
        @(posedge pclk) disable iff (!presetn)
        ctrl_r[0] |=> !can_tx_pu && can_tx_oe;
    endproperty
    a_pp: assert property (p_pp) else $error("push-pull pullup on"); // RL4

    property p_pudr;
        @(posedge pclk) disable iff (!presetn)
        pudr_irq_r |=> !ext_request_pu;
    endproperty
    a_pudr: assert property (p_pudr) else $error("irq pullup on"); // RL13

    sequence s_fall_a;
        cfg_r[0] && prev_n_r[0] && !req_n[0];
    endsequence
    property p_edge;
        @(posedge pclk) disable iff (!presetn) s_fall_a |=> stat_r[0];
    endproperty
    a_edge: assert property (p_edge) else $error("edge lost"); // RL12

    property p_sync;
        @(posedge pclk) disable iff (!presetn)
        !low_power |-> req_a_n == $past(ext_request_a_pin_n, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("sync depth"); // RL11

    property p_gpio_oe;
        @(posedge pclk) disable iff (!presetn)
        sel_r[0] |=> shared_oe[0] == $past(ddr_r[0]);
    endproperty
    a_gpio_oe: assert property (p_gpio_oe) else $error("gpio dir"); // RL8

    property p_tmr_oe;
        @(posedge pclk) disable iff (!presetn)
        !sel_r[2] |=> shared_oe[2] == $past(timer_d_oe[0]);
    endproperty
    a_tmr_oe: assert property (p_tmr_oe) else $error("timer route"); // RL14

    // Reset release, seen at the first edge after it
    sequence s_rst_done;
        $rose(presetn);
    endsequence
    property p_can_rst;
        @(posedge pclk) disable iff (!presetn)
        s_rst_done |-> can_tx_pu && !can_tx_oe && can_gpio_pullup_enable_bits_r;
    endproperty
    a_can_rst: assert property (p_can_rst) else $error("can reset"); // RL1

    property p_sel_rst;
        @(posedge pclk) disable iff (!presetn)
        s_rst_done |-> sel_r == '0 && shared_oe == '0;
    endproperty
    a_sel_rst: assert property (p_sel_rst) else $error("sel reset"); // RL7

    property p_pur_off;
        @(posedge pclk) disable iff (!presetn)
        !pur_r[3] |=> !shared_pu[3];
    endproperty
    a_pur_off: assert property (p_pur_off) else $error("pad pullup on"); // RL9

    property p_async;
        @(posedge pclk) disable iff (!presetn)
        low_power |-> req_a_n == ext_request_a_pin_n;
    endproperty
    a_async: assert property (p_async) else $error("async path"); // RL10

    property p_level;
        @(posedge pclk) disable iff (!presetn)
        !cfg_r[0] && !req_n[0] |=> stat_r[0];
    endproperty
    a_level: assert property (p_level) else $error("level lost"); // RL12

    sequence s_fall_b;
        cfg_r[1] && prev_n_r[1] && !req_n[1];
    endsequence
    property p_edge_b;
        @(posedge pclk) disable iff (!presetn) s_fall_b |=> stat_r[1];
    endproperty
    a_edge_b: assert property (p_edge_b) else $error("edge b lost"); // RL12

    property p_tc_route;
        @(posedge pclk) disable iff (!presetn)
        !sel_r[1] |=> shared_out[1] == $past(timer_c_out[1]);
    endproperty
    a_tc_route: assert property (p_tc_route) else $error("tc route"); // RL5

    property p_tin;
        @(posedge pclk) disable iff (!presetn)
        sel_r[0] |=> timer_c_in[0] == 1'b0;
    endproperty
    a_tin: assert property (p_tin) else $error("timer in"); // RL14
endmodule : pad_pins

// ---- verification/pad_partner.sv ----
`timescale 1ns/1ps
// Outside parts: sensors on the shared pads, requesters on request lines
module pad_partner (
    input  wire logic [5:0] shared_out,
    input  wire logic [5:0] shared_oe,
    input  wire logic [5:0] ext_val,
    input  wire logic       req_a,
    input  wire logic       req_b,
    output logic      [5:0] shared_in,
    output logic            ext_request_a_pin_n,
    output logic            ext_request_b_pin_n
);
    // Design driver overrides the weak outside source on a shared pad
    assign shared_in = (shared_oe & shared_out) | (~shared_oe & ext_val);
    // Requesters drive push-pull, low while they want service
    assign ext_request_a_pin_n = ~req_a;
    assign ext_request_b_pin_n = ~req_b;
endmodule : pad_partner

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic        pready, pslverr, can_tx_data, can_tx_out, can_tx_oe;
    logic        can_tx_pu, ext_request_pu, irq, req_a, req_b;
    logic        ext_request_a_pin_n, ext_request_b_pin_n;
    logic        ext_req_a_n, ext_req_b_n;
    logic [1:0]  tc_out, tc_oe, timer_c_in;
    logic [3:0]  td_out, td_oe, timer_d_in;
    logic [5:0]  shared_in, shared_out, shared_oe, shared_pu;
    logic [5:0]  ext_val, oe, pv;
    int          failures = 0;
    int          compares = 0;
    int          cyc = 0;

    pad_pins i_pad_pins (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .can_tx_data,
        .can_tx_out, .can_tx_oe, .can_tx_pu, .timer_c_out(tc_out),
        .timer_c_oe(tc_oe), .timer_d_out(td_out), .timer_d_oe(td_oe),
        .timer_c_in, .timer_d_in, .shared_in, .shared_out, .shared_oe,
        .shared_pu, .ext_request_a_pin_n, .ext_request_b_pin_n,
        .ext_request_pu, .ext_req_a_n, .ext_req_b_n, .irq);
    pad_partner i_pad_partner (.shared_out, .shared_oe, .ext_val, .req_a,
        .req_b, .shared_in, .ext_request_a_pin_n, .ext_request_b_pin_n);

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // Level seen on a pad given who drives it
    function logic [5:0] padv(input logic [5:0] e, o, v);
        return (e & o) | (~e & v);
    endfunction : padv

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk

    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    // One APB transfer; request held until pready seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the hang guard ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            test_done;
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, req_a, req_b} = 6'h00;
        {paddr, pwdata, ext_val} = 46'h0;
        {tc_out, tc_oe, td_out, td_oe} = 12'h000;
        can_tx_data = 1'b1;
        rnd = 32'h2009;
        wt(16);
        chk(32'({can_tx_pu, shared_pu, ext_request_pu, irq}), 32'h1fe);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, pad_pkg::IRQ_MASK_OFF, 32'h0);
        // Open drain then push-pull on the CAN transmit pad
        wt(2);
        chk(32'({can_tx_oe, can_tx_pu}), 32'h1);
        can_tx_data <= 1'b0;
        wt(3);
        chk(32'({can_tx_oe, can_tx_out, can_tx_pu}), 32'h4);
        can_tx_data <= 1'b1;
        apb(1'b1, pad_pkg::CAN_GPIO_PULLUP_ENABLE_BITS_OFF, 32'h0);
        wt(3);
        chk(32'(can_tx_pu), 32'h0);
        apb(1'b1, pad_pkg::CTRL_OFF, 32'h1);
        for (int d = 0; d < 2; d++) begin
            can_tx_data <= d[0];
            wt(3);
            chk(32'({can_tx_oe, can_tx_out, can_tx_pu}), 32'(4 + 2 * d));
        end
        apb(1'b1, pad_pkg::CTRL_OFF, 32'h0);
        $display("test can pad done");
        // Shared pads in timer use with random drive and pull-ups
        apb(1'b0, pad_pkg::PE_SEL_OFF, 32'h0);
        chk(rd, 32'h0);
        repeat (8) begin
            rnd = lfsr(rnd);
            {tc_out, tc_oe, td_out, td_oe, ext_val} <= rnd[17:0];
            apb(1'b1, pad_pkg::PE_PUR_OFF, 32'(rnd[29:24]));
            wt(3);
            oe = {td_oe, tc_oe};
            pv = padv(oe, {td_out, tc_out}, ext_val);
            chk(32'(shared_oe), 32'(oe));
            chk(32'(shared_out & oe), 32'(pv & oe));
            chk(32'({timer_d_in, timer_c_in}), 32'(pv));
            chk(32'(shared_pu), 32'(rnd[29:24] & ~oe));
        end
        $display("test timer use done");
        // Same pads as port E bits, timers still active behind them
        apb(1'b1, pad_pkg::PE_SEL_OFF, 32'h3f);
        repeat (8) begin
            rnd = lfsr(rnd);
            ext_val <= rnd[17:12];
            apb(1'b1, pad_pkg::PE_DDR_OFF, 32'(rnd[5:0]));
            apb(1'b1, pad_pkg::PE_DOUT_OFF, 32'(rnd[11:6]));
            wt(3);
            oe = rnd[5:0];
            pv = padv(oe, rnd[11:6], ext_val);
            chk(32'(shared_oe), 32'(oe));
            chk(32'(shared_out & oe), 32'(pv & oe));
            chk(32'({timer_d_in, timer_c_in}), 32'h0);
            apb(1'b0, pad_pkg::PE_DIN_OFF, 32'h0);
            chk(rd, 32'(pv));
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        $display("test port e done");
        // Reset in mid-run returns pads to timer use
        presetn <= 1'b0;
        wt(2);
        chk(32'({can_tx_pu, shared_pu, shared_oe}), 32'h1fc0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, pad_pkg::PE_SEL_OFF, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
        // Request lines: pull-up, synchroniser delay, both senses
        apb(1'b1, pad_pkg::SYS_PUDR_OFF, 32'h1);
        wt(2);
        chk(32'(ext_request_pu), 32'h0);
        @(posedge pclk);
        req_a <= 1'b1;
        wt(2);
        chk(32'(ext_req_a_n), 32'h1);
        wt(2);
        chk(32'(ext_req_a_n), 32'h0);
        chk(32'(irq), 32'h0);
        apb(1'b1, pad_pkg::IRQ_MASK_OFF, 32'h3);
        wt(2);
        chk(32'(irq), 32'h1);
        req_a <= 1'b0;
        wt(4);
        apb(1'b1, pad_pkg::IRQ_STAT_OFF, 32'h1);
        wt(2);
        chk(32'(irq), 32'h0);
        apb(1'b1, pad_pkg::IRQ_CFG_OFF, 32'h3);
        req_b <= 1'b1;
        wt(5);
        chk(32'(ext_req_b_n), 32'h0);
        apb(1'b0, pad_pkg::IRQ_STAT_OFF, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, pad_pkg::IRQ_STAT_OFF, 32'h2);
        wt(3);
        apb(1'b0, pad_pkg::IRQ_STAT_OFF, 32'h0);
        chk(rd, 32'h0);
        req_b <= 1'b0;
        apb(1'b1, pad_pkg::CTRL_OFF, 32'h2);
        req_a <= 1'b1;
        // Async path shows two edges before the synchroniser could
        wt(2);
        chk(32'(ext_req_a_n), 32'h0);
        @(posedge pclk);
        chk(32'(irq), 32'h1);
        $display("test requests done");
        test_done;
    end
endmodule : testbench
